// ---- scd_pkg.sv ----
// Package of constants and carriers for the serial command frame decoder
package scd_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int CNT_W = 8;
  localparam logic [1:0] CMD_DIAG = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;
  localparam logic [7:0] DEF_MAP = 8'h08;
  localparam logic [7:0] DEF_OTHER = 8'h00;
  localparam logic [2:0] ADDR_MAP = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [1:0] DIAG_SHORT = 2'h0;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_OVER = 2'h2;
  localparam logic [1:0] DIAG_NORMAL = 2'h3;
  localparam logic [15:0] READ_HDR = 16'h4000;

  typedef struct packed {
    logic [1:0] cmd;
    logic [2:0] zero;
    logic [2:0] addr;
    logic [7:0] data;
  } scd_frame_s;
endpackage

// ---- scd_decoder.sv ----
// Serial command frame decoder sampling the link pins on the system clock
// Functional notes
// [RQ1] Control and diagnosis registers reset to defaults
// [RQ2] Frame: cmd, zeros, pointer, data fields
// [RQ3] Data byte is written or read value
// [RQ4] Diagnosis command changes no register
// [RQ5] Read returns register in next frame
// [RQ6] Reset command restores all register defaults; the code skips register 6, which keeps loading the status bits
// [RQ7] Write stores data into pointed register
// [RQ8] Commands: 00 diag, 01 read, 10 reset, 11 write
// [RQ9] Select fall loads diagnosis; idle ignores, tristates
// [RQ10] Decode only on nonzero multiple of eight clocks
// [RQ11] Sample on falling, shift on rising, MSB first
// [RQ12] Diagnosis: two-bit code per channel
`timescale 1ns/1ps
`default_nettype none
module scd_decoder #(
  parameter int CHANNELS = 8
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic cs_n_pin, // Chip select, active low
  input wire logic sclk_pin, // Serial clock from the master
  input wire logic si_pin, // Serial data in
  output logic so_o, // Serial data out
  output logic so_oe, // Serial out enable, high while driving
  input wire logic [2*CHANNELS-1:0] diag_in, // Per-channel two-bit diagnosis codes
  output logic [8*7-1:0] regs_o, // Registers 1..7, register 1 lowest
  output logic diag_clr_o, // Pulse: diagnosis flags cleared
  input wire logic cmd_ready, // Consumer accepts decoded frame
  output logic cmd_valid, // Decoded frame available
  output scd_pkg::scd_frame_s cmd_frame // Decoded frame
);
  // Channel count is fixed by the sixteen-bit diagnosis word layout
  if (CHANNELS != 8)
  begin : g_bad_channels
    $error("scd_decoder supports exactly eight channels");
  end

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Three-flop pin samplers; a change counts when stages two and three agree
  logic [2:0] cs_s_q, ck_s_q, si_s_q;
  logic cs_q, ck_q, si_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s_q <= 3'h7;
      ck_s_q <= 3'h0;
      si_s_q <= 3'h0;
      cs_q <= 1'b1;
      ck_q <= 1'b0;
      si_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[1:0], cs_n_pin};
      ck_s_q <= {ck_s_q[1:0], sclk_pin};
      si_s_q <= {si_s_q[1:0], si_pin};
      if (cs_s_q[1] == cs_s_q[2])
        cs_q <= cs_s_q[2];
      if (ck_s_q[1] == ck_s_q[2])
        ck_q <= ck_s_q[2];
      if (si_s_q[1] == si_s_q[2])
        si_q <= si_s_q[2];
    end
  end

  logic cs_fall, cs_rise, ck_fall, ck_rise, cs_dg, ck_dg;
  assign cs_dg = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_q;
  assign ck_dg = (ck_s_q[1] == ck_s_q[2]) ? ck_s_q[2] : ck_q;
  assign cs_fall = cs_q && !cs_dg;
  assign cs_rise = !cs_q && cs_dg;
  // Clock edges count only inside a frame
  assign ck_fall = !cs_q && ck_q && !ck_dg; // [RQ9]
  assign ck_rise = !cs_q && !ck_q && ck_dg; // [RQ9]

  // Shift registers: input captured on falling edges, output shifted on rising
  logic [15:0] in_sh_q, out_sh_q;
  logic [scd_pkg::CNT_W-1:0] bit_cnt_q;
  logic [15:0] read_word_q;
  logic read_pend_q;
  logic [7:0] reg_q [1:7];
  logic [15:0] diag_word;
  assign diag_word = diag_in; // [RQ12]

  // Status bit per channel: set while the channel reports normal operation
  logic [7:0] status_bits;
  for (genvar c = 0; c < 8; c++)
  begin : g_status
    assign status_bits[c] = diag_in[2*c +: 2] == scd_pkg::DIAG_NORMAL; // [RQ12]
  end

  // Input shift and clock count
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_sh_q <= 16'h0000;
      bit_cnt_q <= '0;
    end
    else if (cs_fall)
      bit_cnt_q <= '0;
    else if (ck_fall)
    begin
      in_sh_q <= {in_sh_q[14:0], si_q}; // [RQ11]
      bit_cnt_q <= bit_cnt_q + 8'h01;
    end
  end

  // Output shift; the first bit is presented from the select fall
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sh_q <= 16'h0000;
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= !cs_dg; // [RQ9]
      if (cs_fall)
      begin
        out_sh_q <= read_pend_q ? read_word_q : diag_word; // [RQ5] [RQ9]
        so_o <= read_pend_q ? read_word_q[15] : diag_word[15];
      end
      else if (ck_rise && bit_cnt_q != 8'h00)
      begin
        // Daisy chain: input bits follow the outgoing word
        out_sh_q <= {out_sh_q[14:0], in_sh_q[15]};
        so_o <= out_sh_q[14]; // [RQ11]
      end
    end
  end

  // Frame end decode
  logic frame_ok;
  scd_pkg::scd_frame_s fr;
  assign fr = in_sh_q; // [RQ2]
  assign frame_ok = cs_rise && bit_cnt_q != 8'h00 && bit_cnt_q[2:0] == 3'h0; // [RQ10]

  // Register file
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 1; i <= 7; i++)
        reg_q[i] <= (i == 1) ? scd_pkg::DEF_MAP : scd_pkg::DEF_OTHER; // [RQ1]
    end
    else
    begin
      reg_q[scd_pkg::ADDR_STATUS] <= status_bits;
      if (frame_ok && fr.cmd == scd_pkg::CMD_RESET) // [RQ6] [RQ8]
      begin
        for (int i = 1; i <= 5; i++)
          reg_q[i] <= (i == 1) ? scd_pkg::DEF_MAP : scd_pkg::DEF_OTHER;
        reg_q[7] <= scd_pkg::DEF_OTHER;
      end
      else if (frame_ok && fr.cmd == scd_pkg::CMD_WRITE && fr.addr != 3'h0
               && fr.addr != scd_pkg::ADDR_STATUS)
        reg_q[fr.addr] <= fr.data; // [RQ3] [RQ7]
      // Diagnosis and read leave the registers alone [RQ4]
    end
  end

  // Read answer latch
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_pend_q <= 1'b0;
      read_word_q <= 16'h0000;
      diag_clr_o <= 1'b0;
    end
    else
    begin
      diag_clr_o <= frame_ok; // [RQ10]
      if (frame_ok)
      begin
        read_pend_q <= (fr.cmd == scd_pkg::CMD_READ); // [RQ5]
        read_word_q <= scd_pkg::READ_HDR | {5'h00, fr.addr,
                       (fr.addr == 3'h0) ? 8'h00 : reg_q[fr.addr]}; // [RQ3]
      end
    end
  end

  // Register outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      regs_o <= {48'h0, scd_pkg::DEF_MAP};
    else
      regs_o <= {reg_q[7], reg_q[6], reg_q[5], reg_q[4], reg_q[3], reg_q[2], reg_q[1]};
  end

  // Two-entry buffer for decoded frames; a frame arriving while both entries are full and nothing pops is lost
  // Valid and frame outputs are registered copies of the next head
  scd_pkg::scd_frame_s buf_q [2];
  scd_pkg::scd_frame_s head_d;
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, wr_q, rd_d;
  logic push, pop;
  assign pop = cmd_valid && cmd_ready;
  assign push = frame_ok && (cnt_q != 2'h2 || pop);
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign rd_d = pop ? !rd_q : rd_q;
  // A frame pushed into the slot that becomes the head bypasses the array
  assign head_d = (push && wr_q == rd_d) ? fr : buf_q[rd_d];
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cmd_valid <= 1'b0;
      cmd_frame <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wr_q] <= fr;
        wr_q <= !wr_q;
      end
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      cmd_valid <= cnt_d != 2'h0;
      cmd_frame <= head_d;
    end
  end

  // Assertions
  a_oe_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_q && !cs_fall |=> !so_oe) else $error("Output enabled while deselected"); // [RQ9]
  a_write_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_ok && fr.cmd == scd_pkg::CMD_WRITE && fr.addr == 3'h2
    |=> reg_q[2] == $past(fr.data)) else $error("Write not stored"); // [RQ7]
  a_reset_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_ok && fr.cmd == scd_pkg::CMD_RESET |=> reg_q[1] == scd_pkg::DEF_MAP
    && reg_q[3] == 8'h00) else $error("Reset command failed"); // [RQ6]
  a_diag_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_ok && fr.cmd == scd_pkg::CMD_DIAG |=> $stable(reg_q[7]))
    else $error("Diagnosis changed a register"); // [RQ4]
  a_bad_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_rise && bit_cnt_q[2:0] != 3'h0 |=> !diag_clr_o)
    else $error("Frame decoded with bad count"); // [RQ10]
  a_read_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_ok && fr.cmd == scd_pkg::CMD_READ |=> read_pend_q)
    else $error("Read answer not armed"); // [RQ5]
  a_cnt_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ck_fall && !cs_fall |=> bit_cnt_q == $past(bit_cnt_q) + 8'h01)
    else $error("Clock count wrong"); // [RQ11]
  a_buf_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_q <= 2'h2) else $error("Buffer overfilled");
endmodule
`default_nettype wire

// ---- scd_host.sv ----
// Host model that sends frames over the serial link
`timescale 1ns/1ps
`default_nettype none
module scd_host (
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock, still outside frames
  output logic si, // Serial data to device
  input wire logic so, // Serial data from device
  input wire logic so_oe // High while device drives so
);
  // Idle: deselected, clock low, data at its pull-down level
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Clock is low at every select change; so is read just before each fall
  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    cs_n = 1'b0;
    #250;
    for (int i = nb - 1; i >= 0; i--)
    begin
      si = tx[i + 16 - nb];
      sclk = 1'b1;
      #40;
      rx[i] = so_oe ? so : ~so;
      sclk = 1'b0;
      #40;
    end
    #250;
    cs_n = 1'b1;
    si = 1'b0;
    #250;
  endtask
endmodule
`default_nettype wire

// ---- scd_decoder_test.sv ----
// Self-checking bench for the serial command frame decoder
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_test;
  logic sys_clk, nrst, cmd_ready, so_o, so_oe, diag_clr_o, cmd_valid, cs_n, sclk, si;
  logic [15:0] diag_in, rx;
  logic [55:0] regs_o;
  logic [7:0] exp_r [1:7];
  scd_pkg::scd_frame_s cmd_frame;
  int n_fail, checked, n_clr;
  scd_decoder u_scd_decoder (.sys_clk(sys_clk), .nrst(nrst), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .si_pin(si), .so_o(so_o), .so_oe(so_oe), .diag_in(diag_in),
    .regs_o(regs_o), .diag_clr_o(diag_clr_o), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd_frame(cmd_frame));
  scd_host u_scd_host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_o), .so_oe(so_oe));
  // 125 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Counts flag-clear pulses
  always @(posedge sys_clk)
    if (diag_clr_o === 1'b1) n_clr++;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
    u_scd_host.xfer({c, 3'h0, a, d}, 16, rx);
  endtask
  task automatic set_def();
    for (int a = 2; a <= 7; a++)
      exp_r[a] = scd_pkg::DEF_OTHER;
    exp_r[1] = scd_pkg::DEF_MAP;
  endtask
  // Status register is derived from the channel codes, not stored
  task automatic chk_regs();
    logic [55:0] e;
    for (int a = 1; a <= 7; a++)
      e[8*(a-1) +: 8] = exp_r[a];
    for (int c = 0; c < 8; c++)
      e[40 + c] = (diag_in[2*c +: 2] === scd_pkg::DIAG_NORMAL);
    chk({8'h00, regs_o}, {8'h00, e});
  endtask
  task automatic t_reset_state();
    set_def();
    chk_regs();
    chk({63'h0, so_oe}, 64'h0);
  endtask
  task automatic t_diag();
    int c0;
    c0 = n_clr;
    send(scd_pkg::CMD_DIAG, 3'h2, 8'h5a);
    chk({48'h0, rx}, {48'h0, diag_in});
    chk_regs();
    chk(64'(n_clr - c0), 64'h1);
  endtask
  // Address 0 and the status address must not take writes
  task automatic t_write();
    logic [7:0] d;
    for (int a = 0; a < 8; a++)
    begin
      d = 8'(a * 37 + 5);
      send(scd_pkg::CMD_WRITE, 3'(a), d);
      if (a != 0 && a != 6) exp_r[a] = d;
    end
    chk_regs();
  endtask
  // A new command rides in the frame that returns the read answer
  task automatic t_read();
    send(scd_pkg::CMD_READ, 3'h3, 8'h00);
    send(scd_pkg::CMD_WRITE, 3'h1, 8'h3c);
    chk({48'h0, rx}, {48'h0, 2'b01, 3'h0, 3'h3, exp_r[3]});
    exp_r[1] = 8'h3c;
    chk_regs();
  endtask
  task automatic t_reset_cmd();
    send(scd_pkg::CMD_RESET, 3'h5, 8'hff);
    set_def();
    chk_regs();
  endtask
  // Twelve clocks is not a multiple of eight: frame must be dropped
  task automatic t_count();
    int c0;
    c0 = n_clr;
    u_scd_host.xfer({scd_pkg::CMD_WRITE, 3'h0, 3'h2, 8'h77}, 12, rx);
    chk_regs();
    chk(64'(n_clr - c0), 64'h0);
  endtask
  // Consumer stalls: two frames held, third lost, then drained in order
  task automatic t_buffer();
    @(posedge sys_clk);
    #1 cmd_ready = 1'b0;
    for (int k = 1; k <= 3; k++)
      send(scd_pkg::CMD_DIAG, 3'h0, 8'(k));
    for (int k = 1; k <= 2; k++)
    begin
      chk({63'h0, cmd_valid}, 64'h1);
      chk({48'h0, cmd_frame}, {48'h0, 8'h00, 8'(k)});
      @(posedge sys_clk);
      #1 cmd_ready = 1'b1;
      @(posedge sys_clk);
      #1 cmd_ready = 1'b0;
      @(posedge sys_clk);
      #1;
    end
    chk({63'h0, cmd_valid}, 64'h0);
    cmd_ready = 1'b1;
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    cmd_ready = 1'b1;
    diag_in = 16'he41b;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    t_reset_state();
    t_diag();
    t_write();
    t_read();
    t_reset_cmd();
    t_count();
    t_buffer();
    tally_and_finish();
  end
  // Watchdog: about twelve times the expected run
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
